// *** bench/interrupt_vector_map_test.sv ***
// Self-checking testbench of the interrupt vector map.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module interrupt_vector_map_test
  import vector_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0, seg_we = 1'b0, space_we = 1'b0, fire = 1'b0;
  logic [5:0] idx = 6'h00;
  logic [SEG_W-1:0] seg_in = 8'h00, vec_seg, seg_out;
  logic [SPACE_W-1:0] space_in = 2'h0, space_out;
  logic [NUM_SRC-1:0] req;
  logic vec_valid, lite_valid;
  logic [NODE_W-1:0] vec_trap;
  logic [OFS_W-1:0] vec_ofs;
  int failures = 0, num_checks = 0, cycles = 0;
  req_source src (.clk(mclk), .fire(fire), .idx(idx), .req(req));
  vector_map uut (.MCLK(mclk), .RSTN(rstn), .REQ(req), .SEG_IN(seg_in), .SEG_WE(seg_we),
    .SPACE_IN(space_in), .SPACE_WE(space_we), .VEC_VALID(vec_valid), .VEC_TRAP(vec_trap),
    .VEC_SEG(vec_seg), .VEC_OFS(vec_ofs), .SEG_OUT(seg_out), .SPACE_OUT(space_out));
  // Variant without the second async serial channel sees the same inputs.
  vector_map #(.ASYNC_ONE_PRESENT(1'b0)) uut_lite (.MCLK(mclk), .RSTN(rstn), .REQ(req),
    .SEG_IN(seg_in), .SEG_WE(seg_we), .SPACE_IN(space_in), .SPACE_WE(space_we),
    .VEC_VALID(lite_valid), .VEC_TRAP(), .VEC_SEG(), .VEC_OFS(), .SEG_OUT(), .SPACE_OUT());
  // Clock and a cycle ceiling that cuts a hang short.
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Raises one source and waits until the answer has settled.
  task automatic fire_one(input int i);
    @(posedge mclk);
    fire <= 1'b1;
    idx <= 6'(i);
    repeat (4) @(posedge mclk);
    #1;
  endtask : fire_one
  task automatic drop;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : drop
  task automatic test_reset;
    `CHK("space", 2'h0, space_out)
    `CHK("seg", 8'h00, seg_out)
    `CHK("valid", 1'b0, vec_valid)
    $display("test_reset done");
  endtask : test_reset
  // Every source alone at the default spacing, unassigned ones included.
  task automatic test_table;
    logic live;
    for (int i = 0; i < NUM_SRC; i++) begin
      live = (i < FIRST_UNASSIGNED);
      fire_one(i);
      `CHK("valid", live, vec_valid)
      if (live) `CHK("trap", TRAP_TABLE[i], vec_trap)
      if (live) `CHK("ofs", {7'h00, TRAP_TABLE[i], 2'h0}, vec_ofs)
      `CHK("lite", live && (i < 21 || i > 25), lite_valid)
      drop();
      `CHK("idle", 1'b0, vec_valid)
    end
    $display("test_table done");
  endtask : test_table
  // Each spacing code on the capture reload node inside a moved segment.
  task automatic test_space;
    logic [15:0] mult [4] = '{16'h4, 16'h8, 16'h10, 16'h2};
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      seg_in <= 8'hA5;
      seg_we <= 1'b1;
      space_in <= 2'(k);
      space_we <= 1'b1;
      @(posedge mclk);
      seg_we <= 1'b0;
      space_we <= 1'b0;
      fire_one(11);
      `CHK("ofs", 16'h0027 * mult[k], vec_ofs)
      `CHK("seg", 8'hA5, vec_seg)
      `CHK("space", 2'(k), space_out)
      drop();
    end
    $display("test_space done");
  endtask : test_space
  // Reset in mid-run with a request up: outputs clear, registers return to defaults.
  task automatic test_midreset;
    @(posedge mclk);
    rstn <= 1'b0;
    fire <= 1'b1;
    idx <= 6'h00;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("rst valid", 1'b0, vec_valid)
    `CHK("rst space", 2'h0, space_out)
    `CHK("rst seg", 8'h00, seg_out)
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK("rst trap", 7'h45, vec_trap)
    `CHK("rst ofs", 16'h0114, vec_ofs)
    `CHK("rst vseg", 8'h00, vec_seg)
    drop();
    `CHK("rst idle", 1'b0, vec_valid)
    $display("test_midreset done");
  endtask : test_midreset
  // Main sequence after a reset held for 16 cycles.
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    test_reset();
    test_table();
    test_space();
    test_midreset();
    complete_run();
  end
endmodule : interrupt_vector_map_test

// *** bench/req_source.sv ***
// Model of the peripheral request sources that feed the vector map.
module req_source
  import vector_map_pkg::*;
(
  input wire logic clk,
  input wire logic fire,
  input wire logic [5:0] idx,
  output logic [NUM_SRC-1:0] req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Holds the chosen request line high for as long as fire stays up.
  always_ff @(posedge clk) begin
    req <= fire ? (NUM_SRC'(1) << idx) : '0;
  end
endmodule : req_source

// *** core/vector_map.sv ***
// Top of the interrupt vector map: request capture, trap lookup and vector address forming.
// Overview of operation
// - Vector address upper bits come from the vector segment register.
// - Spacing field in the first CPU control register scales vector addresses.
// - After reset the spacing is 4 bytes, two words.
// - Second async serial nodes act only when that channel is present.
// - First general timer block maps to traps 22h, 23h, 24h.
// - Second timer block maps to 25h, 26h, capture reload to 27h.
// - Capture compare timers 0,1 use 20h,21h; timers 7,8 use 3Dh,3Eh.
// - Capture compare registers 30 and 31 use traps 45h and 46h.
// - First async serial uses 2Ah, 47h, 2Bh, 2Ch and 5Fh.
// - First sync serial uses traps 2Dh, 2Eh and 2Fh.
// - Clock loss monitor uses trap 43h.
// - Event subchannel end uses trap 4Ch.
// - Second async serial uses 48h, 5Eh, 49h, 4Ah and 42h.
// - Motor PWM unit uses 4Dh, 4Eh, 4Fh and 50h.
// - Second sync serial uses traps 51h, 52h and 53h.
// - Traps 28h,29h,3Fh,40h,41h,4Bh,54h-5Dh have no source.
module vector_map
  import vector_map_pkg::*;
#(
  parameter bit ASYNC_ONE_PRESENT = 1'b1
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [vector_map_pkg::NUM_SRC-1:0] REQ,
  input wire logic [vector_map_pkg::SEG_W-1:0] SEG_IN,
  input wire logic SEG_WE,
  input wire logic [vector_map_pkg::SPACE_W-1:0] SPACE_IN,
  input wire logic SPACE_WE,
  output logic VEC_VALID,
  output logic [vector_map_pkg::NODE_W-1:0] VEC_TRAP,
  output logic [vector_map_pkg::SEG_W-1:0] VEC_SEG,
  output logic [vector_map_pkg::OFS_W-1:0] VEC_OFS,
  output logic [vector_map_pkg::SEG_W-1:0] SEG_OUT,
  output logic [vector_map_pkg::SPACE_W-1:0] SPACE_OUT
);
  import vector_map_pkg::*;

  logic [NUM_SRC-1:0] req_q, req_d;
  logic [SEG_W-1:0] seg_q, seg_d;
  logic [SPACE_W-1:0] space_q, space_d;
  logic valid_q, valid_d;
  logic [NODE_W-1:0] trap_q, trap_d;
  logic [SEG_W-1:0] vseg_q, vseg_d;
  logic [OFS_W-1:0] ofs_q, ofs_d;
  logic [OFS_W-1:0] base_ofs;

  vector_req_if pick ();

  // Sources are same-clock logic; requests are registered once before lookup.
  vector_select #(.ASYNC_ONE_PRESENT(ASYNC_ONE_PRESENT)) u_select (
    .req(req_q),
    .out(pick.sel)
  );

  // Control register next values and the scaled offset of the picked node.
  always_comb begin
    req_d = REQ;
    seg_d = SEG_WE ? SEG_IN : seg_q;
    space_d = SPACE_WE ? SPACE_IN : space_q;
    base_ofs = {{(OFS_W-NODE_W){1'b0}}, pick.trap};
    case (space_q)
      SPACE_8B: ofs_d = base_ofs << 3;
      SPACE_16B: ofs_d = base_ofs << 4;
      SPACE_2B: ofs_d = base_ofs << 1;
      default: ofs_d = base_ofs << 2;
    endcase
    valid_d = pick.hit;
    trap_d = pick.trap;
    vseg_d = seg_q;
  end

  // All state registers, reset to defaults.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      req_q <= '0;
      seg_q <= SEG_RESET;
      space_q <= SPACE_RESET;
      valid_q <= 1'b0;
      trap_q <= '0;
      vseg_q <= SEG_RESET;
      ofs_q <= '0;
    end else begin
      req_q <= req_d;
      seg_q <= seg_d;
      space_q <= space_d;
      valid_q <= valid_d;
      trap_q <= trap_d;
      vseg_q <= vseg_d;
      ofs_q <= ofs_d;
    end
  end

  assign VEC_VALID = valid_q;
  assign VEC_TRAP = trap_q;
  assign VEC_SEG = vseg_q;
  assign VEC_OFS = ofs_q;
  assign SEG_OUT = seg_q;
  assign SPACE_OUT = space_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // Only requests that can legally reach the output count; absent channel nodes are excluded.
  sequence s_req_seen;
    (|REQ[FIRST_ASYNC_ONE-1:0]) || (|REQ[FIRST_UNASSIGNED-1:LAST_ASYNC_ONE+1]) ||
      (ASYNC_ONE_PRESENT && (|REQ[LAST_ASYNC_ONE:FIRST_ASYNC_ONE]));
  endsequence

  a_reset_spacing: assert property ($rose(RSTN) |-> space_q == SPACE_RESET)
    else $error("Spacing not at default after reset.");
  a_default_offset: assert property (VEC_VALID && SPACE_OUT == SPACE_RESET &&
      $past(space_q) == SPACE_RESET |-> VEC_OFS == {7'h00, VEC_TRAP, 2'b00})
    else $error("Offset not trap times four.");
  a_offset_eight: assert property (VEC_VALID && $past(space_q) == SPACE_8B
      |-> VEC_OFS == {6'h00, VEC_TRAP, 3'b000})
    else $error("Offset not trap times eight.");
  a_segment_used: assert property (SEG_WE ##1 !SEG_WE ##1 1'b1
      |-> VEC_SEG == $past(SEG_IN, 2))
    else $error("Vector segment does not follow register.");
  a_no_unassigned: assert property (VEC_VALID |-> VEC_TRAP != 7'h28 && VEC_TRAP != 7'h29 &&
      !(VEC_TRAP inside {7'h3F, 7'h40, 7'h41, 7'h4B}) &&
      !(VEC_TRAP inside {[7'h54:7'h5D]}))
    else $error("Vector issued for unassigned node.");
  a_req_to_vec: assert property (s_req_seen |-> ##2 VEC_VALID)
    else $error("Live request produced no vector.");
  a_async_one_gate: assert property (ASYNC_ONE_PRESENT || !VEC_VALID ||
      !(VEC_TRAP inside {7'h48, 7'h5E, 7'h49, 7'h4A, 7'h42}))
    else $error("Absent channel raised a vector.");
  a_timer_a_trap: assert property (REQ[6] && !(|REQ[5:0]) |-> ##2 VEC_TRAP == 7'h22)
    else $error("Timer block a trap wrong.");
  a_ccr30_trap: assert property (REQ[0] |-> ##2 VEC_TRAP == 7'h45)
    else $error("Capture register 30 trap wrong.");
endmodule : vector_map

// *** core/vector_map_pkg.sv ***
// Package with trap numbers, vector spacing encodings and reset values of the vector map.
package vector_map_pkg;
  localparam int NODE_W = 7;
  localparam int SEG_W = 8;
  localparam int OFS_W = 16;
  localparam int SPACE_W = 2;
  localparam logic [SEG_W-1:0] SEG_RESET = 8'h00;
  // Spacing field: 0 gives 4 bytes, 1 gives 8, 2 gives 16, 3 gives 2.
  localparam logic [SPACE_W-1:0] SPACE_RESET = 2'h0;
  localparam logic [SPACE_W-1:0] SPACE_8B = 2'h1;
  localparam logic [SPACE_W-1:0] SPACE_16B = 2'h2;
  localparam logic [SPACE_W-1:0] SPACE_2B = 2'h3;
  localparam int NUM_SRC = 45;
  // Trap numbers of each connected source, in source-index order.
  localparam logic [NODE_W-1:0] TRAP_TABLE [NUM_SRC] = '{
    7'h45, 7'h46, 7'h20, 7'h21, 7'h3D, 7'h3E,          // capture_compare_unit
    7'h22, 7'h23, 7'h24,                               // general_timer_block_a
    7'h25, 7'h26, 7'h27,                               // general_timer_block_b
    7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h5F,                 // async_serial_zero
    7'h2D, 7'h2E, 7'h2F,                               // sync_serial_zero
    7'h43,                                             // clock_loss_monitor
    7'h48, 7'h5E, 7'h49, 7'h4A, 7'h42,                 // async_serial_one
    7'h4C,                                             // peripheral_event_channel
    7'h4D, 7'h4E, 7'h4F, 7'h50,                        // motor_pwm_unit
    7'h51, 7'h52, 7'h53,                               // sync_serial_one
    7'h28, 7'h29, 7'h3F, 7'h40, 7'h41, 7'h4B, 7'h54,   // unassigned
    7'h55, 7'h56, 7'h57, 7'h58};
  localparam int FIRST_ASYNC_ONE = 21;
  localparam int LAST_ASYNC_ONE = 25;
  localparam int FIRST_UNASSIGNED = 34;
endpackage : vector_map_pkg

// *** core/vector_req_if.sv ***
// Interface carrying the selected request between the select leaf and the top.
interface vector_req_if;
  import vector_map_pkg::*;
  logic hit;
  logic [NODE_W-1:0] trap;
  modport sel (output hit, output trap);
  modport top (input hit, input trap);
endinterface : vector_req_if

// *** core/vector_select.sv ***
// Combinational pick of the lowest-index live source and its trap number.
module vector_select
  import vector_map_pkg::*;
#(
  parameter bit ASYNC_ONE_PRESENT = 1'b1
) (
  input wire logic [NUM_SRC-1:0] req,
  vector_req_if.sel out
);
  // Lowest index wins; async_serial_one only counts in variants that have it.
  always_comb begin
    out.hit = 1'b0;
    out.trap = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && i < FIRST_UNASSIGNED &&
          (ASYNC_ONE_PRESENT || i < FIRST_ASYNC_ONE || i > LAST_ASYNC_ONE)) begin
        out.hit = 1'b1;
        out.trap = TRAP_TABLE[i];
      end
    end
  end
endmodule : vector_select
